// ==== src/cms_defs.vh ====
// Register map, field positions, reset values and select codes of the comparator control.
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH

// ==========================================================
// Bus and register offsets
`define CMS_ADDR_W 8
`define CMS_DATA_W 8
`define CMS_MODE_OFS 8'h9c
`define CMS_MUX_OFS 8'h9f
`define CMS_STAT_OFS 8'ha0
`define CMS_CLR_OFS 8'ha1
`define CMS_IEN_OFS 8'ha2
`define CMS_LVL_OFS 8'ha3
`define CMS_RD_NONE 8'h00

// ==========================================================
// Mode register layout and reset value
`define CMS_MODE_RST 8'h82
`define CMS_MODE_RSV 7
`define CMS_MODE_RIE 5
`define CMS_MODE_FIE 4
`define CMS_MODE_SP_HI 1
`define CMS_MODE_SP_LO 0
`define CMS_SP_RST 2'h2

// ==========================================================
// Input select register layout and reset value
`define CMS_MUX_RST 8'hff
`define CMS_MUX_NEG_HI 7
`define CMS_MUX_NEG_LO 4
`define CMS_MUX_POS_HI 3
`define CMS_MUX_POS_LO 0
`define CMS_SEL_RST 4'hf

// ==========================================================
// Select codes
`define CMS_SEL_NEG_RSV 4'hb
`define CMS_SEL_POS_PMAX 4'hb
`define CMS_SEL_TOUCH 4'hc
`define CMS_SEL_HALF 4'hd
`define CMS_SEL_SUP_A 4'he
`define CMS_SEL_SUP_B 4'hf

// ==========================================================
// Decoded source kinds
`define CMS_SRC_W 3
`define CMS_SRC_PIN 3'h0
`define CMS_SRC_TOUCH 3'h1
`define CMS_SRC_HALF 3'h2
`define CMS_SRC_SUP_A 3'h3
`define CMS_SRC_SUP_B 3'h4
`define CMS_SRC_NONE 3'h5

// ==========================================================
// Event status layout: two bits per comparator, rise then fall
`define CMS_NCMP 2
`define CMS_ST_W 4
`define CMS_ST_PER 2
`define CMS_ST_RISE 0
`define CMS_ST_FALL 1
`define CMS_ST_RST 4'h0
`define CMS_IEN_RST 4'h0

`endif

// ==== src/cms_sync.v ====
// Two-stage synchroniser with edge detection for comparator outputs.
`timescale 1ns/100ps
module cms_sync #(
  parameter W = 2
) (
  // Clock, reset, enable
  input wire clock,
  input wire rst,
  input wire clk_en,
  // Asynchronous levels in
  input wire [W-1:0] async_in,
  // Synchronised level and edge pulses out
  output wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  reg [W-1:0] stage1_reg;
  reg [W-1:0] stage2_reg;
  reg [W-1:0] prev_reg;

  // ==========================================================
  // Synchroniser and history
  always @(posedge clock)
  begin
    if (rst)
    begin
      stage1_reg <= {W{1'b0}};
      stage2_reg <= {W{1'b0}};
      prev_reg <= {W{1'b0}};
    end
    else if (clk_en)
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      prev_reg <= stage2_reg;
    end
  end

  assign level = stage2_reg;
  assign rise = stage2_reg & ~prev_reg;
  assign fall = ~stage2_reg & prev_reg;

endmodule // cms_sync

// ==== src/cms_ctrl.v ====
// Comparator mode and input select registers with edge flags and interrupts.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "cms_defs.vh"
module cms_ctrl #(
  parameter ADDR_W = `CMS_ADDR_W,
  parameter DATA_W = `CMS_DATA_W
) (
  // Clock, reset, enable
  input wire clock,
  input wire rst,
  input wire clk_en,
  // Register port
  input wire [ADDR_W-1:0] addr,
  input wire [DATA_W-1:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [DATA_W-1:0] rdata,
  // Raw comparator outputs from the analog cores
  input wire cmp0_out_raw,
  input wire cmp1_out_raw,
  // Comparator 1 mode controls
  output reg [1:0] cmp1_speed_power_sel,
  output reg cmp1_rise_irq_en,
  output reg cmp1_fall_irq_en,
  // Comparator 0 input multiplexer controls
  output reg [3:0] cmp0_neg_sel,
  output reg [3:0] cmp0_pos_sel,
  output reg [`CMS_SRC_W-1:0] cmp0_neg_src,
  output reg [`CMS_SRC_W-1:0] cmp0_pos_src,
  output reg cmp0_neg_touch_ref,
  output reg cmp0_pos_touch_ref,
  output reg cmp0_neg_half_div_en,
  output reg cmp0_pos_half_div_en,
  // Timer capture sources
  output reg cmp0_capture,
  output reg cmp1_capture,
  // Interrupts
  output reg cmp1_irq,
  output reg irq
);

  // ==========================================================
  // Select code decoding
  // Maps a four-bit select code to the kind of source it connects.
  function [`CMS_SRC_W-1:0] src_kind;
    input [3:0] code;
    input is_neg;
    begin
      case (code)
        `CMS_SEL_TOUCH:
          src_kind = `CMS_SRC_TOUCH;
        `CMS_SEL_HALF:
          src_kind = `CMS_SRC_HALF;
        `CMS_SEL_SUP_A:
          src_kind = `CMS_SRC_SUP_A;
        `CMS_SEL_SUP_B:
          src_kind = `CMS_SRC_SUP_B;
        `CMS_SEL_NEG_RSV:
          src_kind = is_neg ? `CMS_SRC_NONE : `CMS_SRC_PIN;
        default:
          src_kind = `CMS_SRC_PIN;
      endcase
    end
  endfunction

  // Write decode shared by all register writes.
  function wr_hit;
    input stb;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ofs;
    begin
      wr_hit = stb && (a == ofs);
    end
  endfunction

  // Compares a select field against one code.
  function sel_is;
    input [3:0] code;
    input [3:0] ref_code;
    begin
      sel_is = (code == ref_code);
    end
  endfunction

  // ==========================================================
  // Declarations
  reg rie_reg;
  reg rie_next;
  reg fie_reg;
  reg fie_next;
  reg [1:0] sp_reg;
  reg [1:0] sp_next;
  reg [DATA_W-1:0] mux_reg;
  reg [DATA_W-1:0] mux_next;
  reg [`CMS_ST_W-1:0] stat_reg;
  wire [`CMS_ST_W-1:0] stat_next;
  reg [`CMS_ST_W-1:0] ien_reg;
  reg [`CMS_ST_W-1:0] ien_next;
  reg [DATA_W-1:0] rdata_next;
  reg [DATA_W-1:0] mode_view;
  wire [`CMS_NCMP-1:0] lvl;
  wire [`CMS_NCMP-1:0] rise;
  wire [`CMS_NCMP-1:0] fall;
  wire [`CMS_ST_W-1:0] clr_mask;
  wire wr_mode;
  wire wr_mux;
  wire wr_clr;
  wire wr_ien;
  wire [3:0] neg_code_next;
  wire [3:0] pos_code_next;
  reg cmp1_irq_next;
  reg irq_next;

  // ==========================================================
  // Address decode
  assign wr_mode = wr_hit(wr_stb, addr, `CMS_MODE_OFS);
  assign wr_mux = wr_hit(wr_stb, addr, `CMS_MUX_OFS);
  assign wr_clr = wr_hit(wr_stb, addr, `CMS_CLR_OFS);
  assign wr_ien = wr_hit(wr_stb, addr, `CMS_IEN_OFS);
  assign clr_mask = wr_clr ? wdata[`CMS_ST_W-1:0] : {`CMS_ST_W{1'b0}};

  // ==========================================================
  // Comparator output synchronisers
  // The stages reset low, so a comparator that is already high when reset
  // ends shows one rising edge; software clears that flag before use.
  // Pulses shorter than one clock period may be missed.
  cms_sync #(
    .W(`CMS_NCMP)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .async_in({cmp1_out_raw, cmp0_out_raw}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // ==========================================================
  // Edge flags: an edge in the cycle of a clear keeps its flag set
  genvar gi;
  generate
    for (gi = 0; gi < `CMS_NCMP; gi = gi + 1)
    begin : g_flag
      // A mode change may make the analog output glitch; such edges are
      // flagged like any other, so software clears the flags afterwards.
      assign stat_next[`CMS_ST_PER*gi+`CMS_ST_RISE] = rise[gi] ||
        (stat_reg[`CMS_ST_PER*gi+`CMS_ST_RISE] &&
        !clr_mask[`CMS_ST_PER*gi+`CMS_ST_RISE]);
      assign stat_next[`CMS_ST_PER*gi+`CMS_ST_FALL] = fall[gi] ||
        (stat_reg[`CMS_ST_PER*gi+`CMS_ST_FALL] &&
        !clr_mask[`CMS_ST_PER*gi+`CMS_ST_FALL]);
    end
  endgenerate

  // ==========================================================
  // Mode register: only the enables and the speed field are stored
  // The reserved top bit is not stored; it is forced to one on read.
  always @*
  begin
    rie_next = rie_reg;
    fie_next = fie_reg;
    sp_next = sp_reg;
    if (wr_mode)
    begin
      rie_next = wdata[`CMS_MODE_RIE];
      fie_next = wdata[`CMS_MODE_FIE];
      sp_next = wdata[`CMS_MODE_SP_HI:`CMS_MODE_SP_LO];
    end
  end

  // Unused bits read zero and the reserved top bit reads one.
  always @*
  begin
    mode_view = {DATA_W{1'b0}};
    mode_view[`CMS_MODE_RSV] = 1'b1;
    mode_view[`CMS_MODE_RIE] = rie_reg;
    mode_view[`CMS_MODE_FIE] = fie_reg;
    mode_view[`CMS_MODE_SP_HI:`CMS_MODE_SP_LO] = sp_reg;
  end

  // ==========================================================
  // Input select and interrupt enable registers
  always @*
  begin
    mux_next = mux_reg;
    if (wr_mux)
    begin
      mux_next = wdata;
    end
  end

  always @*
  begin
    ien_next = ien_reg;
    if (wr_ien)
    begin
      ien_next = wdata[`CMS_ST_W-1:0];
    end
  end

  // ==========================================================
  // Read data: valid only in the cycle after the read strobe
  // The clear register is write-only and reads as zero.
  always @*
  begin
    rdata_next = `CMS_RD_NONE;
    if (rd_stb)
    begin
      case (addr)
        `CMS_MODE_OFS:
          rdata_next = mode_view;
        `CMS_MUX_OFS:
          rdata_next = mux_reg;
        `CMS_STAT_OFS:
          rdata_next = {{(DATA_W-`CMS_ST_W){1'b0}}, stat_reg};
        `CMS_IEN_OFS:
          rdata_next = {{(DATA_W-`CMS_ST_W){1'b0}}, ien_reg};
        `CMS_CLR_OFS:
          rdata_next = `CMS_RD_NONE;
        `CMS_LVL_OFS:
          rdata_next = {{(DATA_W-`CMS_NCMP){1'b0}}, lvl};
        default:
          rdata_next = `CMS_RD_NONE;
      endcase
    end
  end

  // ==========================================================
  // State registers
  always @(posedge clock)
  begin
    if (rst)
    begin
      rie_reg <= 1'b0;
      fie_reg <= 1'b0;
      sp_reg <= `CMS_SP_RST;
      mux_reg <= `CMS_MUX_RST;
      stat_reg <= `CMS_ST_RST;
      ien_reg <= `CMS_IEN_RST;
      rdata <= `CMS_RD_NONE;
    end
    else if (clk_en)
    begin
      rie_reg <= rie_next;
      fie_reg <= fie_next;
      sp_reg <= sp_next;
      mux_reg <= mux_next;
      stat_reg <= stat_next;
      ien_reg <= ien_next;
      rdata <= rdata_next;
    end
  end

  // ==========================================================
  // Next contents of the two select fields
  assign neg_code_next = mux_next[`CMS_MUX_NEG_HI:`CMS_MUX_NEG_LO];
  assign pos_code_next = mux_next[`CMS_MUX_POS_HI:`CMS_MUX_POS_LO];

  // ==========================================================
  // Comparator 1 mode outputs, registered from next values
  // so that they change in the same cycle as the register contents.
  always @(posedge clock)
  begin
    if (rst)
    begin
      cmp1_speed_power_sel <= `CMS_SP_RST;
      cmp1_rise_irq_en <= 1'b0;
      cmp1_fall_irq_en <= 1'b0;
    end
    else if (clk_en)
    begin
      cmp1_speed_power_sel <= sp_next;
      cmp1_rise_irq_en <= rie_next;
      cmp1_fall_irq_en <= fie_next;
    end
  end

  // ==========================================================
  // Comparator 0 multiplexer outputs; the divider is powered only while
  // its code is selected, so it draws nothing otherwise.
  always @(posedge clock)
  begin
    if (rst)
    begin
      cmp0_neg_sel <= `CMS_SEL_RST;
      cmp0_pos_sel <= `CMS_SEL_RST;
      cmp0_neg_src <= `CMS_SRC_SUP_B;
      cmp0_pos_src <= `CMS_SRC_SUP_B;
      cmp0_neg_touch_ref <= 1'b0;
      cmp0_pos_touch_ref <= 1'b0;
      cmp0_neg_half_div_en <= 1'b0;
      cmp0_pos_half_div_en <= 1'b0;
    end
    else if (clk_en)
    begin
      cmp0_neg_sel <= neg_code_next;
      cmp0_pos_sel <= pos_code_next;
      cmp0_neg_src <= src_kind(neg_code_next, 1'b1);
      cmp0_pos_src <= src_kind(pos_code_next, 1'b0);
      cmp0_neg_touch_ref <= sel_is(neg_code_next, `CMS_SEL_TOUCH);
      cmp0_pos_touch_ref <= sel_is(pos_code_next, `CMS_SEL_TOUCH);
      cmp0_neg_half_div_en <= sel_is(neg_code_next, `CMS_SEL_HALF);
      cmp0_pos_half_div_en <= sel_is(pos_code_next, `CMS_SEL_HALF);
    end
  end

  // ==========================================================
  // Interrupt requests, formed from next values so that a flag and the
  // request that it raises appear at the same edge.
  always @*
  begin
    cmp1_irq_next = (stat_next[`CMS_ST_PER+`CMS_ST_RISE] && rie_next) ||
      (stat_next[`CMS_ST_PER+`CMS_ST_FALL] && fie_next);
    irq_next = |(stat_next & ien_next);
  end

  // ==========================================================
  // Timer capture sources and interrupt outputs
  always @(posedge clock)
  begin
    if (rst)
    begin
      cmp0_capture <= 1'b0;
      cmp1_capture <= 1'b0;
      cmp1_irq <= 1'b0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      cmp0_capture <= lvl[0];
      cmp1_capture <= lvl[1];
      cmp1_irq <= cmp1_irq_next;
      irq <= irq_next;
    end
  end

endmodule // cms_ctrl

// ==== verification/cms_ctrl_monitor.sv ====
// Checker of the comparator control ports.
`timescale 1ns/100ps
`include "cms_defs.vh"
module cms_ctrl_monitor #(
  parameter ADDR_W = 8,
  parameter DATA_W = 8
) (
  // Clock and bus
  input wire clock,
  input wire rst,
  input wire clk_en,
  input wire [ADDR_W-1:0] addr,
  input wire [DATA_W-1:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [DATA_W-1:0] rdata,
  // Comparator side
  input wire cmp0_out_raw,
  input wire cmp1_out_raw,
  input wire [1:0] cmp1_speed_power_sel,
  input wire cmp1_rise_irq_en,
  input wire cmp1_fall_irq_en,
  input wire [3:0] cmp0_neg_sel,
  input wire [3:0] cmp0_pos_sel,
  input wire [2:0] cmp0_neg_src,
  input wire [2:0] cmp0_pos_src,
  input wire cmp0_neg_touch_ref,
  input wire cmp0_pos_touch_ref,
  input wire cmp0_neg_half_div_en,
  input wire cmp0_pos_half_div_en,
  // Timers and interrupts
  input wire cmp0_capture,
  input wire cmp1_capture,
  input wire cmp1_irq,
  input wire irq
);
  // Negative code 1011 connects nothing; the top four codes are internal sources.
  function [2:0] src_of(input [3:0] c, input neg);
  begin
    if (c == 4'hb && neg)
      src_of = 3'h5;
    else if (c < 4'hc)
      src_of = 3'h0;
    else
      src_of = c[2:0] - 3'h3;
  end
  endfunction
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // Registers and multiplexers
  a_mode_read: assert property ($past(rd_stb && clk_en && addr == `CMS_MODE_OFS) |->
    rdata == {2'h2, cmp1_rise_irq_en, cmp1_fall_irq_en, 2'h0, cmp1_speed_power_sel})
    else $error("mode read back wrong");
  a_mode_write: assert property ($past(wr_stb && clk_en && addr == `CMS_MODE_OFS) |->
    {cmp1_rise_irq_en, cmp1_fall_irq_en, cmp1_speed_power_sel} == $past({wdata[5:4], wdata[1:0]}))
    else $error("mode write not applied");
  a_neg_source: assert property (cmp0_neg_src == src_of(cmp0_neg_sel, 1'b1))
    else $error("negative source decode wrong");
  a_pos_source: assert property (cmp0_pos_src == src_of(cmp0_pos_sel, 1'b0))
    else $error("positive source decode wrong");
  a_touch_ref: assert property ({cmp0_neg_touch_ref, cmp0_pos_touch_ref} ==
    {cmp0_neg_sel == 4'hc, cmp0_pos_sel == 4'hc}) else $error("touch reference wrong");
  a_half_div: assert property ({cmp0_neg_half_div_en, cmp0_pos_half_div_en} ==
    {cmp0_neg_sel == 4'hd, cmp0_pos_sel == 4'hd}) else $error("divider enable wrong");
  // ==========================================================
  // Edges, capture and interrupt
  a_capture_follow: assert property ((clk_en && $stable({cmp0_out_raw, cmp1_out_raw}))[*4] |->
    {cmp0_capture, cmp1_capture} == {cmp0_out_raw, cmp1_out_raw}) else $error("capture stale");
  a_rise_irq: assert property ($rose(cmp1_out_raw) && cmp1_rise_irq_en && clk_en |->
    ##[1:4] cmp1_irq) else $error("rise interrupt missing");
  a_irq_off: assert property (!cmp1_rise_irq_en && !cmp1_fall_irq_en &&
    !$past(cmp1_rise_irq_en) && !$past(cmp1_fall_irq_en) |-> !cmp1_irq)
    else $error("interrupt with enables off");
endmodule  // cms_ctrl_monitor

// ==== verification/cms_cmp_model.sv ====
// Behavioural comparator pair that drives the raw outputs.
`timescale 1ns/100ps
module cms_cmp_model (
  // Clock and speed mode
  input wire clock,
  input wire [1:0] speed_sel,
  // Wanted and driven levels
  input wire [1:0] target,
  output wire [1:0] raw
);
  reg [1:0] raw_reg = 2'h0;
  reg [2:0] wait_reg = 3'h0;
  assign raw = raw_reg;
  // Slower modes take longer to follow a change of the inputs.
  always @(posedge clock)
  begin
    if (target == raw_reg)
      wait_reg <= 3'h0;
    else if (wait_reg == {1'b0, speed_sel})
    begin
      raw_reg <= target;
      wait_reg <= 3'h0;
    end
    else
      wait_reg <= wait_reg + 3'h1;
  end
endmodule  // cms_cmp_model

// ==== verification/cms_ctrl_tb.sv ====
// Self-checking bench of the comparator control registers.
`timescale 1ns/100ps
`include "cms_defs.vh"
module cms_ctrl_tb;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg clk_en = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg [1:0] target = 2'h0;
  wire [7:0] rdata;
  wire [1:0] raw;
  wire [1:0] sp;
  wire [3:0] nsel, psel;
  wire rie, fie, ntr, ptr, nhd, phd, cap0, cap1, c1irq, irq;
  integer failures = 0;
  integer tests_run = 0;
  integer i;
  always #2.5 clock = ~clock;
  cms_cmp_model i_cms_cmp_model (.clock(clock), .speed_sel(sp), .target(target), .raw(raw));
  cms_ctrl i_cms_ctrl (.clock(clock), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cmp0_out_raw(raw[0]),
    .cmp1_out_raw(raw[1]), .cmp1_speed_power_sel(sp), .cmp1_rise_irq_en(rie),
    .cmp1_fall_irq_en(fie), .cmp0_neg_sel(nsel), .cmp0_pos_sel(psel), .cmp0_neg_src(),
    .cmp0_pos_src(), .cmp0_neg_touch_ref(ntr), .cmp0_pos_touch_ref(ptr),
    .cmp0_neg_half_div_en(nhd), .cmp0_pos_half_div_en(phd), .cmp0_capture(cap0),
    .cmp1_capture(cap1), .cmp1_irq(c1irq), .irq(irq));
  task chk_byte(input [7:0] got, input [7:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    #1;
  end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
  begin
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk_byte(rdata, exp);
  end
  endtask
  task settle;
  begin
    repeat (12) @(posedge clock);
    #1;
  end
  endtask
  task summarize;
  begin
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    failures = failures + 1;
    summarize;
  end
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(`CMS_MODE_OFS, 8'h82);
    rd(`CMS_MUX_OFS, 8'hff);
    wr(`CMS_MODE_OFS, 8'hff);
    rd(`CMS_MODE_OFS, 8'hb3);
    @(posedge clock);
    clk_en <= 1'b0;
    wr(`CMS_MODE_OFS, 8'h80);
    @(posedge clock);
    clk_en <= 1'b1;
    rd(`CMS_MODE_OFS, 8'hb3);
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`CMS_MODE_OFS, {6'h20, i[1:0]});
      chk_byte({rie, fie, sp}, i[1:0]);
    end
    for (i = 0; i < 16; i = i + 1)
    begin
      wr(`CMS_MUX_OFS, {i[3:0], ~i[3:0]});
      chk_byte({nsel, psel}, {i[3:0], ~i[3:0]});
      chk_byte({ntr, ptr}, {i[3:0] == 4'hc, i[3:0] == 4'h3});
      chk_byte({nhd, phd}, {i[3:0] == 4'hd, i[3:0] == 4'h2});
    end
    rd(`CMS_MUX_OFS, 8'hf0);
    wr(`CMS_MODE_OFS, 8'ha3);
    target <= 2'h2;
    settle;
    chk_byte({c1irq, irq, cap1, cap0}, 4'ha);
    rd(`CMS_STAT_OFS, 8'h04);
    rd(`CMS_LVL_OFS, 8'h02);
    target <= 2'h0;
    settle;
    rd(`CMS_STAT_OFS, 8'h0c);
    wr(`CMS_CLR_OFS, 8'h04);
    settle;
    chk_byte(c1irq, 1'b0);
    wr(`CMS_MODE_OFS, 8'h93);
    settle;
    chk_byte(c1irq, 1'b1);
    wr(`CMS_CLR_OFS, 8'h0f);
    rd(`CMS_STAT_OFS, 8'h00);
    wr(`CMS_IEN_OFS, 8'h01);
    target <= 2'h1;
    settle;
    chk_byte({irq, c1irq}, 2'h2);
    wr(`CMS_IEN_OFS, 8'h00);
    settle;
    chk_byte(irq, 1'b0);
    rd(`CMS_STAT_OFS, 8'h01);
    summarize;
  end
endmodule  // cms_ctrl_tb
bind cms_ctrl cms_ctrl_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_cms_ctrl_monitor (
  .clock(clock), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .cmp0_out_raw(cmp0_out_raw), .cmp1_out_raw(cmp1_out_raw),
  .cmp1_speed_power_sel(cmp1_speed_power_sel), .cmp1_rise_irq_en(cmp1_rise_irq_en),
  .cmp1_fall_irq_en(cmp1_fall_irq_en), .cmp0_neg_sel(cmp0_neg_sel),
  .cmp0_pos_sel(cmp0_pos_sel), .cmp0_neg_src(cmp0_neg_src), .cmp0_pos_src(cmp0_pos_src),
  .cmp0_neg_touch_ref(cmp0_neg_touch_ref), .cmp0_pos_touch_ref(cmp0_pos_touch_ref),
  .cmp0_neg_half_div_en(cmp0_neg_half_div_en), .cmp0_pos_half_div_en(cmp0_pos_half_div_en),
  .cmp0_capture(cmp0_capture), .cmp1_capture(cmp1_capture), .cmp1_irq(cmp1_irq), .irq(irq));
